// ==== core/spfc_pkg.sv ====
`default_nettype none
package spfc_pkg;
    localparam logic [5:0] CSR_ADDR      = 6'h37;
    localparam logic [7:0] CSR_RESET     = 8'h00;
    localparam int BIT_ENABLE            = 0;
    localparam int BIT_ERASE             = 1;
    localparam int BIT_WRITE             = 2;
    localparam int BIT_LOCKSEL           = 3;
    localparam int BIT_REENABLE          = 4;
    localparam int BIT_RESERVED          = 5;
    localparam int BIT_BUSY              = 6;
    localparam int BIT_IRQEN             = 7;
    localparam logic [4:0] CMD_FILL      = 5'h01;
    localparam logic [4:0] CMD_ERASE     = 5'h03;
    localparam logic [4:0] CMD_WRITE     = 5'h05;
    localparam logic [4:0] CMD_LOCKRD    = 5'h09;
    localparam logic [4:0] CMD_REENABLE  = 5'h11;
    localparam logic [2:0] SPM_WINDOW    = 3'd4;
    localparam logic [2:0] LPM_WINDOW    = 3'd3;
    localparam logic [15:0] PTR_FUSE_LO  = 16'h0000;
    localparam logic [15:0] PTR_LOCK     = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HI  = 16'h0003;
    localparam int CLK_MHZ               = 40;
    localparam int PROG_TIME_US          = 4500;
    localparam int PROG_CYCLES           = PROG_TIME_US * CLK_MHZ;
    typedef enum logic [1:0] {
        SPFC_IDLE  = 2'b00,
        SPFC_ARMED = 2'b01,
        SPFC_PROG  = 2'b11
    } spfc_state_t;
endpackage : spfc_pkg
`default_nettype wire

// ==== core/spfc_page_buf.sv ====
`default_nettype none
module spfc_page_buf #(
    parameter int WORDS_LOG2 = 5
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  clk_en_in,
    input  wire logic                  clear_in,
    input  wire logic                  load_in,
    input  wire logic [WORDS_LOG2-1:0] addr_in,
    input  wire logic [15:0]           data_in,
    input  wire logic [WORDS_LOG2-1:0] rd_addr_in,
    output logic      [15:0]           rd_data_out,
    output logic                       filling_out
);
    localparam int WORDS = 1 << WORDS_LOG2;
    logic [15:0]      mem [WORDS];
    logic [WORDS-1:0] valid;

    initial begin
        if (WORDS_LOG2 < 1 || WORDS_LOG2 > 8) $error("bad WORDS_LOG2");
    end

    // Cleared buffer words read as erased flash
    generate
        for (genvar i = 0; i < WORDS; i++) begin : g_word
            always_ff @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    valid[i] <= 1'b0;
                    mem[i]   <= 16'hffff;
                end else if (clk_en_in) begin
                    if (clear_in) begin
                        valid[i] <= 1'b0;
                        mem[i]   <= 16'hffff;
                    end else if (load_in && addr_in == WORDS_LOG2'(i)) begin
                        valid[i] <= 1'b1;
                        mem[i]   <= data_in;
                    end
                end
            end
        end
    endgenerate

    assign rd_data_out = mem[rd_addr_in];
    assign filling_out = |valid;
endmodule : spfc_page_buf
`default_nettype wire

// ==== core/spfc_ctrl.sv ====
// Behaviour
// RULE1: Enable bit permits a store-program only for four following cycles.
// RULE2: Pattern 00001 stores register pair into page buffer at pointer.
// RULE3: Enable clears after a store-program or after four idle cycles.
// RULE4: Enable stays high until an erase or write finishes.
// RULE5: Pattern 00101 then store-program writes buffer to pointer's page.
// RULE6: Page-write bit clears at completion or four-cycle expiry.
// RULE7: Pattern 00011 then store-program erases pointer's page.
// RULE8: Page-erase bit clears at completion or four-cycle expiry.
// RULE9: Only five listed control patterns take effect; others do nothing.
// RULE10: Re-enable during buffer fill clears the whole page buffer.
// RULE11: Lock-select plus enable: load within three cycles returns fuse/lock.
// RULE12: Ready interrupt requested while enable low and enables set.
// RULE13: Ready interrupt suppressed during EEPROM write or store-program.
// RULE14: Bit 5 reads zero; busy bit zero in small variant.
// RULE15: Busy bit high while concurrent region blocked; re-enable clears it.
// RULE16: Core stalled for programming in no-concurrent-read region.
// RULE17: Core not stalled for programming in concurrent-read region.
// RULE18: Software avoids the concurrent region while it is programmed.
// RULE19: Programming only starts from store-program in boot loader region.
// RULE20: Any page may be targeted, including boot loader pages.
// RULE21: Software polls for idle and no EEPROM write before commanding.
// RULE22: EEPROM write blocks programming and fuse/lock reads.
// RULE23: Pointer 1 lock, 0 fuse low, 3 fuse high, 2 extended fuse.
// RULE24: Page address is latched once programming starts.
// RULE25: Windows count from the cycle the register write takes effect.
`default_nettype none
module spfc_ctrl
    import spfc_pkg::*;
#(
    parameter int PAGE_WORDS_LOG2 = 5,
    parameter int PAGE_BITS       = 8,
    parameter int NO_CONCURRENT_READ_REGION_FIRST_PAGE = 192,
    parameter int HAS_RWW         = 1,
    parameter int PROG_COUNT      = spfc_pkg::PROG_CYCLES
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 rstn_in,
    input  wire logic                 clk_en_in,
    input  wire logic [5:0]           io_addr_in,
    input  wire logic                 io_wr_in,
    input  wire logic [7:0]           io_wdata_in,
    output logic      [7:0]           io_rdata_out,
    input  wire logic                 spm_in,
    input  wire logic                 lpm_in,
    input  wire logic                 exec_in_boot_in,
    input  wire logic [15:0]          pointer_in,
    input  wire logic [15:0]          reg_pair_in,
    input  wire logic                 global_irq_en_in,
    input  wire logic                 eeprom_write_busy_in,
    input  wire logic [7:0]           lock_bits_in,
    input  wire logic [7:0]           fuse_lo_in,
    input  wire logic [7:0]           fuse_hi_in,
    input  wire logic [7:0]           fuse_ext_in,
    output logic                      lpm_special_out,
    output logic      [7:0]           lpm_data_out,
    output logic                      core_stall_out,
    output logic                      ready_irq_out,
    output logic                      flash_erase_out,
    output logic                      flash_write_out,
    output logic      [PAGE_BITS-1:0] flash_page_out,
    output logic      [15:0]          flash_wdata_out,
    input  wire logic                 flash_done_in
);
    localparam int WORDS = 1 << PAGE_WORDS_LOG2;
    localparam int PB_LO = PAGE_WORDS_LOG2 + 1;

    initial begin
        if (PB_LO + PAGE_BITS > 16) $error("page field exceeds pointer");
        if (NO_CONCURRENT_READ_REGION_FIRST_PAGE >= (1 << PAGE_BITS)) $error("bad NO_CONCURRENT_READ_REGION start");
        if (PROG_COUNT < 1) $error("PROG_COUNT must be positive");
    end

    spfc_state_t state;
    spfc_state_t next_state;
    logic [4:0]  ctl;
    logic        irq_en;
    logic        busy;
    logic [2:0]  win;
    logic [31:0] prog_cnt;
    logic        prog_erase;
    logic [PAGE_BITS-1:0]       page;
    logic [PAGE_WORDS_LOG2-1:0] wr_idx;
    logic [15:0] buf_rd;
    logic        filling;

    // External strobe-free levels come from the same clock domain
    wire csr_wr    = io_wr_in && io_addr_in == CSR_ADDR;
    wire [4:0] cmd = io_wdata_in[4:0];
    wire cmd_ok    = cmd == CMD_FILL || cmd == CMD_ERASE ||
                     cmd == CMD_WRITE || cmd == CMD_LOCKRD ||
                     cmd == CMD_REENABLE;
    // Writes with enable low only touch the interrupt enable
    wire accept    = csr_wr && cmd_ok && !eeprom_write_busy_in &&
                     state != SPFC_PROG; // RULE9 RULE22
    wire armed     = state == SPFC_ARMED;
    wire spm_go    = armed && spm_in && exec_in_boot_in &&
                     !eeprom_write_busy_in && win != 3'd0; // RULE1 RULE19
    wire lpm_go    = armed && lpm_in && ctl == CMD_LOCKRD &&
                     !eeprom_write_busy_in &&
                     win > SPM_WINDOW - LPM_WINDOW; // RULE11
    wire [PAGE_BITS-1:0] ptr_page = pointer_in[PB_LO +: PAGE_BITS];
    wire ptr_no_concurrent_read_region  = ptr_page >= NO_CONCURRENT_READ_REGION_FIRST_PAGE[PAGE_BITS-1:0]; // RULE20
    wire is_prog   = ctl == CMD_ERASE || ctl == CMD_WRITE;
    wire start     = spm_go && is_prog;
    wire fill_go   = spm_go && ctl == CMD_FILL; // RULE2
    wire reen_go   = spm_go && ctl == CMD_REENABLE;
    wire expire    = armed && win == 3'd1 && !spm_go && !lpm_go; // RULE25
    wire prog_end  = state == SPFC_PROG && prog_cnt == 32'd1 &&
                     flash_done_in;
    // Buffer survives an erase, so it may be filled before or after one
    wire buf_clear = (reen_go && filling) ||
                     (prog_end && !prog_erase); // RULE10

    function automatic logic [7:0] fuse_sel(input logic [15:0] p,
            input logic [7:0] lk, input logic [7:0] lo,
            input logic [7:0] hi, input logic [7:0] ex);
        case (p)
            PTR_LOCK:     fuse_sel = lk;
            PTR_FUSE_LO:  fuse_sel = lo;
            PTR_FUSE_HI:  fuse_sel = hi;
            PTR_FUSE_EXT: fuse_sel = ex;
            default:      fuse_sel = 8'hff;
        endcase
    endfunction : fuse_sel

    always_comb begin
        next_state = state;
        case (state)
            SPFC_IDLE:  if (accept) next_state = SPFC_ARMED;
            SPFC_ARMED: begin
                if (start)
                    next_state = SPFC_PROG;
                else if (spm_go || lpm_go || expire)
                    next_state = SPFC_IDLE; // RULE3
            end
            SPFC_PROG:  if (prog_end) next_state = SPFC_IDLE; // RULE4
            default:    next_state = SPFC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= SPFC_IDLE;
            ctl   <= CSR_RESET[4:0];
            win   <= 3'd0;
        end else if (clk_en_in) begin
            state <= next_state;
            if (accept) begin
                ctl <= cmd;
                win <= SPM_WINDOW; // RULE1
            end else if (armed && win != 3'd0) begin
                win <= win - 3'd1;
            end
            if (next_state == SPFC_IDLE && state != SPFC_IDLE)
                ctl <= 5'h00; // RULE6 RULE8
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_en <= CSR_RESET[BIT_IRQEN];
        end else if (clk_en_in && csr_wr) begin
            irq_en <= io_wdata_in[BIT_IRQEN];
        end
    end

    // Busy flag only exists on variants with the concurrent region
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy <= 1'b0;
        end else if (clk_en_in && HAS_RWW != 0) begin
            if (start && !ptr_no_concurrent_read_region)
                busy <= 1'b1; // RULE15
            else if (reen_go && state != SPFC_PROG)
                busy <= 1'b0; // RULE15
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prog_cnt   <= 32'd0;
            prog_erase <= 1'b0;
            page       <= '0;
            wr_idx     <= '0;
        end else if (clk_en_in) begin
            if (start) begin
                prog_cnt   <= PROG_COUNT;
                prog_erase <= ctl == CMD_ERASE; // RULE7
                page       <= ptr_page; // RULE24
                wr_idx     <= '0;
            end else if (state == SPFC_PROG) begin
                if (prog_cnt > 32'd1)
                    prog_cnt <= prog_cnt - 32'd1;
                wr_idx <= wr_idx + 1'b1;
            end
        end
    end

    spfc_page_buf #(
        .WORDS_LOG2 (PAGE_WORDS_LOG2)
    ) u_buf (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .clk_en_in   (clk_en_in),
        .clear_in    (buf_clear), // RULE10
        .load_in     (fill_go), // RULE2
        .addr_in     (pointer_in[PAGE_WORDS_LOG2:1]),
        .data_in     (reg_pair_in),
        .rd_addr_in  (wr_idx),
        .rd_data_out (buf_rd),
        .filling_out (filling)
    );

    // Stall covers the whole operation for pages in the halted region
    wire prog_now   = state == SPFC_PROG && !prog_end;
    wire stall_next = start ? ptr_no_concurrent_read_region :
                      prog_now && page >= NO_CONCURRENT_READ_REGION_FIRST_PAGE[PAGE_BITS-1:0];
    wire irq_next   = irq_en && global_irq_en_in && !ctl[BIT_ENABLE] &&
                      next_state == SPFC_IDLE &&
                      !eeprom_write_busy_in; // RULE12 RULE13
    wire [7:0] rd_next = {irq_en, busy, 1'b0, ctl}; // RULE14

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            io_rdata_out    <= CSR_RESET;
            lpm_special_out <= 1'b0;
            lpm_data_out    <= 8'h00;
            core_stall_out  <= 1'b0;
            ready_irq_out   <= 1'b0;
            flash_erase_out <= 1'b0;
            flash_write_out <= 1'b0;
            flash_page_out  <= '0;
            flash_wdata_out <= 16'h0000;
        end else if (clk_en_in) begin
            io_rdata_out    <= rd_next;
            lpm_special_out <= lpm_go;
            lpm_data_out    <= fuse_sel(pointer_in, lock_bits_in,
                                        fuse_lo_in, fuse_hi_in,
                                        fuse_ext_in); // RULE23
            core_stall_out  <= stall_next; // RULE16 RULE17
            ready_irq_out   <= irq_next;
            flash_erase_out <= start ? ctl == CMD_ERASE
                                     : prog_now && prog_erase;
            flash_write_out <= start ? ctl == CMD_WRITE // RULE5
                                     : prog_now && !prog_erase;
            flash_page_out  <= start ? ptr_page : page;
            flash_wdata_out <= buf_rd;
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in || !clk_en_in);

    window_expiry_a: assert property ( // RULE1
        accept ##1 (!spm_in && !lpm_in)[*4] |=> state == SPFC_IDLE)
        else $error("enable did not expire after four cycles");
    enable_clears_a: assert property ( // RULE3
        state == SPFC_ARMED && spm_go && !is_prog |=> !ctl[BIT_ENABLE])
        else $error("enable stayed after store-program");
    prog_holds_a: assert property ( // RULE4
        state == SPFC_PROG && !prog_end |=> ctl[BIT_ENABLE])
        else $error("enable dropped during programming");
    bad_pattern_a: assert property ( // RULE9
        state == SPFC_IDLE && csr_wr && !cmd_ok |=> state == SPFC_IDLE)
        else $error("illegal pattern armed the block");
    eeprom_block_a: assert property ( // RULE22
        eeprom_write_busy_in && state == SPFC_ARMED |-> !spm_go && !lpm_go)
        else $error("operation during EEPROM write");
    stall_no_concurrent_read_region_a: assert property ( // RULE16
        start && ptr_no_concurrent_read_region |=> core_stall_out)
        else $error("no stall for halted region");
    no_stall_rww_a: assert property ( // RULE17
        start && !ptr_no_concurrent_read_region |=> !core_stall_out)
        else $error("stall for concurrent region");
    app_spm_a: assert property ( // RULE19
        state == SPFC_ARMED && spm_in && !exec_in_boot_in |-> !start)
        else $error("programming started from application");
    page_latch_a: assert property ( // RULE24
        state == SPFC_PROG && $past(state) == SPFC_PROG |->
        $stable(page))
        else $error("page changed during programming");
    irq_gate_a: assert property ( // RULE13
        state == SPFC_PROG |=> !ready_irq_out)
        else $error("ready interrupt during programming");
    reserved_a: assert property ( // RULE14
        io_rdata_out[BIT_RESERVED] == 1'b0)
        else $error("reserved bit read one");

    state_freeze_a: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !clk_en_in |=> $stable(state) && $stable(ctl) && $stable(win))
        else $error("state moved while clock enable low");

    fill_clear_a: assert property ( // RULE10
        reen_go && filling |=> !filling)
        else $error("page buffer kept data after re-enable");

    lock_pulse_a: assert property ( // RULE11
        lpm_go |=> lpm_special_out)
        else $error("special load not flagged");

    lock_window_a: assert property ( // RULE11
        accept ##4 lpm_in |-> !lpm_go)
        else $error("special load after three cycles");

    irq_on_a: assert property ( // RULE12
        state == SPFC_IDLE && !accept && irq_en && global_irq_en_in &&
        !eeprom_write_busy_in |=> ready_irq_out)
        else $error("ready interrupt missing");

    irq_ee_a: assert property ( // RULE13
        eeprom_write_busy_in |=> !ready_irq_out)
        else $error("ready interrupt during EEPROM write");

    busy_set_a: assert property ( // RULE15
        start && !ptr_no_concurrent_read_region && HAS_RWW != 0 |=> busy)
        else $error("busy bit not set");

    busy_clear_a: assert property ( // RULE15
        reen_go |=> !busy)
        else $error("busy bit not cleared by re-enable");

    expire_clear_a: assert property ( // RULE8
        expire |=> ctl == 5'h00)
        else $error("command bits kept after expiry");

    write_start_a: assert property ( // RULE5
        start && ctl == CMD_WRITE |=> flash_write_out && !flash_erase_out)
        else $error("page write not started");

    erase_start_a: assert property ( // RULE7
        start && ctl == CMD_ERASE |=> flash_erase_out && !flash_write_out)
        else $error("page erase not started");

    stall_hold_a: assert property ( // RULE16
        state == SPFC_PROG && !prog_end &&
        page >= NO_CONCURRENT_READ_REGION_FIRST_PAGE[PAGE_BITS-1:0] |=> core_stall_out)
        else $error("stall dropped during halted programming");

    cov_erase: cover property (start && ctl == CMD_ERASE);
    cov_write: cover property (start && ctl == CMD_WRITE);
    cov_lock:  cover property (lpm_go);
    cov_expire: cover property (expire);
    cov_freeze: cover property (disable iff (!rstn_in) !clk_en_in && armed);
endmodule : spfc_ctrl
`default_nettype wire

// ==== testbench/spfc_flash_model.sv ====
`default_nettype none
// Flash array seen from the sequencer: it reports ready to finish, either
// at once or only after a slow start to every erase or write.
module spfc_flash_model (
    input  wire logic core_clk_in,
    input  wire logic rstn_in,
    input  wire logic busy_in,
    input  wire logic slow_in,
    output logic      done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] age;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            age <= 5'h00;
        end else if (!busy_in) begin
            age <= 5'h00;
        end else if (age != 5'h1f) begin
            age <= age + 5'h01;
        end
    end
    // A slow array holds off completion past the sequencer's own count
    assign done_out = !slow_in || (age > 5'h18);
endmodule : spfc_flash_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import spfc_pkg::*;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [5:0] io_addr_in = CSR_ADDR;
    logic io_wr_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic spm_in = 1'b0;
    logic lpm_in = 1'b0;
    logic boot_in = 1'b1;
    logic [15:0] pointer_in = 16'h0000;
    logic [15:0] pair_in = 16'h0000;
    logic gie_in = 1'b0;
    logic ee_busy = 1'b0;
    logic slow = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] rdata, lpm_data, page;
    logic [15:0] wdata;
    logic lpm_sp, stall, irq, erase, write, done;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    spfc_ctrl #(.PROG_COUNT(20)) DUT (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_wdata_in(io_wdata_in), .io_rdata_out(rdata),
        .spm_in(spm_in), .lpm_in(lpm_in), .exec_in_boot_in(boot_in),
        .pointer_in(pointer_in), .reg_pair_in(pair_in),
        .global_irq_en_in(gie_in), .eeprom_write_busy_in(ee_busy),
        .lock_bits_in(8'hc3), .fuse_lo_in(8'h62), .fuse_hi_in(8'hdf),
        .fuse_ext_in(8'hf9), .lpm_special_out(lpm_sp),
        .lpm_data_out(lpm_data), .core_stall_out(stall),
        .ready_irq_out(irq), .flash_erase_out(erase),
        .flash_write_out(write), .flash_page_out(page),
        .flash_wdata_out(wdata), .flash_done_in(done));
    spfc_flash_model flash (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .busy_in(erase | write), .slow_in(slow), .done_out(done));

    always #12.5 core_clk_in = ~core_clk_in;

    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask : tick
    task automatic csr_wr(input logic [7:0] d);
        for (int n = 0; n < 100 && rdata[BIT_ENABLE] !== 1'b0; n++) tick();
        io_wr_in = 1'b1;
        io_wdata_in = d;
        tick();
        io_wr_in = 1'b0;
        tick();
    endtask : csr_wr
    task automatic spm_go();
        spm_in = 1'b1;
        tick();
        spm_in = 1'b0;
    endtask : spm_go

    task automatic t_fill();
        csr_wr({3'h0, CMD_FILL});
        repeat (2) tick();
        `CHK("armed", 1'b1, rdata[BIT_ENABLE])
        repeat (5) tick();
        `CHK("expired", 8'h00, rdata)
        pair_in = 16'h5a3c;
        csr_wr({3'h0, CMD_FILL});
        spm_go();
        repeat (2) tick();
        `CHK("filled", 8'h00, rdata)
        `CHK("no op", 1'b0, erase | write)
    endtask : t_fill

    task automatic t_freeze();
        csr_wr({3'h0, CMD_FILL});
        clk_en = 1'b0;
        spm_go();
        repeat (5) tick();
        `CHK("frozen", 1'b1, rdata[BIT_ENABLE])
        clk_en = 1'b1;
        spm_go();
        repeat (2) tick();
        `CHK("thawed", 1'b0, rdata[BIT_ENABLE])
    endtask : t_freeze

    task automatic t_refuse();
        csr_wr(8'h07);
        io_addr_in = 6'h36;
        csr_wr({3'h0, CMD_FILL});
        io_addr_in = CSR_ADDR;
        ee_busy = 1'b1;
        csr_wr({3'h0, CMD_ERASE});
        spm_go();
        ee_busy = 1'b0;
        tick();
        `CHK("refused", 8'h00, rdata)
        `CHK("ee block", 1'b0, erase | stall)
        csr_wr({3'h0, CMD_ERASE});
        ee_busy = 1'b1;
        spm_go();
        ee_busy = 1'b0;
        tick();
        `CHK("ee armed", 1'b0, erase | stall)
        repeat (3) tick();
    endtask : t_refuse

    task automatic t_lock();
        logic [7:0] exp, got;
        logic seen;
        for (int i = 0; i < 4; i++) begin
            pointer_in = 16'(i);
            exp = (i == 0) ? 8'h62 : (i == 1) ? 8'hc3 :
                  (i == 2) ? 8'hf9 : 8'hdf;
            csr_wr({3'h0, CMD_LOCKRD});
            lpm_in = 1'b1;
            tick();
            lpm_in = 1'b0;
            seen = 1'b0;
            got = 8'h00;
            repeat (3) begin
                if (lpm_sp === 1'b1) begin
                    seen = 1'b1;
                    got = lpm_data;
                end
                tick();
            end
            `CHK("special", 1'b1, seen)
            `CHK("fuse byte", exp, got)
            repeat (4) tick();
        end
    endtask : t_lock

    task automatic t_prog(input logic [4:0] cmd, input logic [7:0] pg,
                          input logic halt, input logic [15:0] wd);
        pointer_in = {2'b00, pg, 6'h00};
        csr_wr({3'h0, cmd});
        spm_go();
        pointer_in = 16'hffff;
        for (int n = 0; n < 3 && (erase | write) !== 1'b1; n++) tick();
        tick();
        `CHK("erase", cmd == CMD_ERASE, erase)
        `CHK("write", cmd == CMD_WRITE, write)
        `CHK("page", pg, page)
        `CHK("stall", halt, stall)
        if (cmd == CMD_WRITE) `CHK("wdata", wd, wdata)
        tick();
        `CHK("held", 1'b1, rdata[BIT_ENABLE])
        `CHK("busy", !halt, rdata[BIT_BUSY])
        for (int n = 0; n < 100 && (erase | write) !== 1'b0; n++) tick();
        repeat (2) tick();
        `CHK("finished", 5'h00, rdata[4:0])
        `CHK("no stall", 1'b0, stall)
    endtask : t_prog

    task automatic t_regions();
        t_prog(CMD_ERASE, 8'd250, 1'b1, 16'hffff);
        slow = 1'b1;
        t_prog(CMD_WRITE, 8'd10, 1'b0, 16'h5a3c);
        slow = 1'b0;
        csr_wr({3'h0, CMD_REENABLE});
        spm_go();
        repeat (2) tick();
        `CHK("reenabled", 8'h00, rdata)
        pointer_in = 16'h0000;
        pair_in = 16'h1234;
        csr_wr({3'h0, CMD_FILL});
        spm_go();
        csr_wr({3'h0, CMD_REENABLE});
        spm_go();
        t_prog(CMD_WRITE, 8'd200, 1'b1, 16'hffff);
        boot_in = 1'b0;
        csr_wr({3'h0, CMD_ERASE});
        spm_go();
        repeat (3) tick();
        `CHK("app spm", 1'b0, erase)
        boot_in = 1'b1;
        repeat (4) tick();
    endtask : t_regions

    task automatic t_irq();
        `CHK("irq rst", 1'b0, irq)
        gie_in = 1'b1;
        csr_wr(8'h80);
        repeat (2) tick();
        `CHK("irq on", 1'b1, irq)
        ee_busy = 1'b1;
        repeat (2) tick();
        `CHK("irq ee", 1'b0, irq)
        ee_busy = 1'b0;
        csr_wr(8'h83);
        spm_go();
        repeat (2) tick();
        `CHK("irq spm", 1'b0, irq)
        for (int n = 0; n < 100 && erase !== 1'b0; n++) tick();
        repeat (2) tick();
        `CHK("irq back", 1'b1, irq)
        gie_in = 1'b0;
    endtask : t_irq

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        #1;
        rstn_in = 1'b1;
        tick();
        `CHK("reset", CSR_RESET, rdata)
        t_fill();
        t_freeze();
        t_refuse();
        t_lock();
        t_regions();
        t_irq();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
